// file: hdl/aef_pkg.sv
package aef_pkg;
	// ****************************************
	// register indices (word address = index)
	// ****************************************
	localparam logic [7:0] IDX_PAIR01_SAT      = 8'h54;
	localparam logic [7:0] IDX_PAIR23_SAT      = 8'h55;
	localparam logic [7:0] IDX_PAIR45_SAT      = 8'h56;
	localparam logic [7:0] IDX_PAIR67_SAT      = 8'h57;
	localparam logic [7:0] IDX_CHAN_CHECK_EN   = 8'h58;
	localparam logic [7:0] IDX_GEN_FAULT       = 8'h59;
	localparam logic [7:0] IDX_GEN_CHECK_EN    = 8'h5a;
	localparam logic [7:0] IDX_SUMMARY_GEN     = 8'h5e;
	localparam logic [7:0] IDX_SUMMARY_SAT     = 8'h5f;
	localparam logic [7:0] IDX_IRQ_STATUS      = 8'h70;
	localparam logic [7:0] IDX_IRQ_MASK        = 8'h71;
	localparam int         ADDR_W              = 8;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_FLAGS           = 8'h00;
	localparam logic [7:0] RST_CHAN_CHECK_EN   = 8'hfe;
	localparam logic [7:0] RST_GEN_CHECK_EN    = 8'h3e;

	// ****************************************
	// field positions
	// ****************************************
	localparam int BIT_OUTPUT_CLAMP_ON   = 7;
	localparam int BIT_FILTER_OVER_ON    = 6;
	localparam int BIT_MOD_OVER_ON       = 5;
	localparam int BIT_SAT_MOD           = 2;
	localparam int BIT_SAT_FILTER        = 1;
	localparam int BIT_SAT_OUTPUT        = 0;
	localparam int ODD_SHIFT             = 3;
	localparam int BIT_REG_IMAGE_CRC     = 5;
	localparam int BIT_FUSE_CRC          = 4;
	localparam int BIT_SPI_CLK_COUNT     = 3;
	localparam int BIT_SPI_BAD_READ      = 2;
	localparam int BIT_SPI_BAD_WRITE     = 1;
	localparam int BIT_SPI_CRC           = 0;
	localparam int BIT_CHIP_ERROR        = 5;
	localparam int BIT_GEN_SUMMARY       = 3;
	localparam int BIT_IRQ_GEN           = 4;

	// ****************************************
	// data widths, limits and timing
	// ****************************************
	localparam int          RAW_W              = 28;
	localparam int          OUT_W              = 24;
	localparam logic [27:0] FILTER_LIMIT       = 28'h0ff_ffff;
	localparam logic [27:0] OUT_LIMIT_POS      = 28'h07f_ffff;
	localparam logic [27:0] OUT_LIMIT_NEG      = 28'hf80_0000;
	localparam logic [5:0]  SPI_EDGES_PLAIN    = 6'h10;
	localparam logic [5:0]  SPI_EDGES_CRC      = 6'h18;
	localparam logic [6:0]  SPI_ADDR_LAST      = 7'h63;
	localparam logic [7:0]  CRC_POLY           = 8'h07;
	localparam int          CLK_PERIOD_NS      = 10;
	localparam int          CRC_PERIOD_NS      = 10000;
	localparam int          CRC_PERIOD_CYC     = CRC_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [9:0]  CRC_PERIOD_LAST    = 10'(CRC_PERIOD_CYC - 1);
endpackage : aef_pkg

// file: hdl/aef_error_flags.sv
// Functional notes
// [R1] four read-only pair saturation registers, even channel in bits 2..0, odd in 5..3, zero at reset.
// [R2] each channel's modulator saturation raises its flag in bit 2 (even) or bit 5 (odd).
// [R3] each channel's pre-calibration filter overrange raises its flag in bit 1 (even) or bit 4 (odd).
// [R4] each out-of-limit conversion is clamped and raises its flag in bit 0 (even) or bit 3 (odd) at once.
// [R5] one read-write channel check enable register, eight bits, reset 0xfe.
// [R6] enable bits 7, 6 and 5 gate output clamp, filter and modulator checks.
// [R7] enable bits 4..1 gate negative and positive input under/over voltage checks; here those bits are only stored, no such checks exist.
// [R8] a periodic CRC of the register image sets general fault bit 5 on mismatch.
// [R9] a periodic CRC of the fuse contents sets general fault bit 4 on error.
// [R10] serial clock edges are counted per frame and a wrong count sets general fault bit 3.
// [R11] a serial read to a nonexistent address sets general fault bit 2.
// [R12] a serial write to an invalid address sets general fault bit 1.
// [R13] the serial CRC check has an enable bit that is off after reset.
// [R14] any flag in a pair register sets that pair's summary bit and the chip error bit.
// [R15] any general fault bit sets the general summary bit in the first status register (0x5e).
// [R16] a flag updates only while its check is enabled and a disabled check holds it at zero.
// [R17] host writes to flag bits are ignored; flags change only by the device's own checks.
`timescale 1ns/1ps
`default_nettype none
module aef_error_flags (
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic [7:0]            avs_address_i,
	input  wire logic                  avs_read_i,
	input  wire logic                  avs_write_i,
	input  wire logic [31:0]           avs_writedata_i,
	input  wire logic [3:0]            avs_byteenable_i,
	output logic      [31:0]           avs_readdata_o,
	output logic                       avs_waitrequest_o,
	output logic                       irq_o,
	input  wire logic [7:0]            mod_sat_i,
	input  wire logic                  conv_valid_i,
	input  wire logic [2:0]            conv_chan_i,
	input  wire logic [27:0]           filt_raw_i,
	input  wire logic [27:0]           conv_raw_i,
	output logic                       conv_valid_o,
	output logic      [2:0]            conv_chan_o,
	output logic      [23:0]           conv_data_o,
	input  wire logic [31:0]           fuse_data_i,
	input  wire logic [7:0]            fuse_crc_i,
	input  wire logic                  spi_sclk_edge_i,
	input  wire logic                  spi_frame_end_i,
	input  wire logic                  spi_access_i,
	input  wire logic                  spi_access_write_i,
	input  wire logic [6:0]            spi_access_addr_i,
	input  wire logic                  spi_crc_bad_i
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] crc8(input logic [31:0] data);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--) begin
			if (c[7] ^ data[i]) begin
				c = {c[6:0], 1'b0} ^ aef_pkg::CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction : crc8

	function automatic logic [27:0] magnitude(input logic [27:0] v);
		return v[27] ? 28'(-v) : v;
	endfunction : magnitude

	// ****************************************
	// registers
	// ****************************************
	logic [7:0]  chan_en_ff;
	logic [7:0]  gen_en_ff;
	logic [2:0]  chan_flags_ff [8];
	logic [7:0]  gen_fault_ff;
	logic [4:0]  irq_status_ff;
	logic [4:0]  irq_mask_ff;
	logic        wait_ff;
	logic [31:0] rdata_ff;
	logic        irq_ff;
	logic        conv_valid_ff;
	logic [2:0]  conv_chan_ff;
	logic [23:0] conv_data_ff;
	logic [9:0]  crc_tick_cnt_ff;
	logic [7:0]  golden_crc_ff;
	logic        image_written_ff;
	logic [5:0]  spi_edges_ff;
	logic [3:0]  pair_any_ff;
	logic        gen_any_ff;

	logic        bus_req;
	logic        wr_now;
	logic        crc_tick;
	logic [7:0]  pair_reg [4];
	logic [3:0]  pair_any;
	logic        gen_any;
	logic [31:0] nxt_rdata;
	logic [7:0]  sum_gen;
	logic [7:0]  sum_sat;
	logic [31:0] image_word;
	logic [27:0] conv_limit_pos;
	logic [27:0] conv_limit_neg;
	logic [4:0]  irq_event;

	assign bus_req        = avs_read_i | avs_write_i;
	assign wr_now         = avs_write_i & ~wait_ff & avs_byteenable_i[0];
	assign crc_tick       = (crc_tick_cnt_ff == aef_pkg::CRC_PERIOD_LAST);
	assign image_word     = {8'h00, chan_en_ff, gen_en_ff, 3'h0, irq_mask_ff};
	assign conv_limit_pos = aef_pkg::OUT_LIMIT_POS;
	assign conv_limit_neg = aef_pkg::OUT_LIMIT_NEG;
	// pair summary rises in bits 3..0, general summary rise in bit 4
	assign irq_event      = {gen_any & ~gen_any_ff, pair_any & ~pair_any_ff};

	// ****************************************
	// avalon slave handshake
	// ****************************************
	// one wait cycle so read data come from a flip-flop
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_ff <= 1'b1;
		end else if (!wait_ff) begin
			wait_ff <= 1'b1;
		end else begin
			wait_ff <= ~bus_req;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_read_i && wait_ff) begin
			rdata_ff <= nxt_rdata;
		end
	end

	always_comb begin
		for (int p = 0; p < 4; p++) begin
			pair_reg[p] = {2'b00, chan_flags_ff[2 * p + 1], chan_flags_ff[2 * p]}; // [R1]
			pair_any[p] = |pair_reg[p];
		end
		gen_any = |gen_fault_ff;
		sum_gen = 8'h00;
		sum_gen[aef_pkg::BIT_GEN_SUMMARY] = gen_any_ff; // [R15]
		sum_gen[aef_pkg::BIT_CHIP_ERROR]  = gen_any_ff | (|pair_any_ff);
		sum_sat = {2'b00, 2'b00, pair_any_ff}; // [R14]
		sum_sat[aef_pkg::BIT_CHIP_ERROR]  = gen_any_ff | (|pair_any_ff); // [R14]
	end

	// unmapped indices read zero and swallow writes
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		unique case (avs_address_i)
			aef_pkg::IDX_PAIR01_SAT:    nxt_rdata = {24'h00_0000, pair_reg[0]};
			aef_pkg::IDX_PAIR23_SAT:    nxt_rdata = {24'h00_0000, pair_reg[1]};
			aef_pkg::IDX_PAIR45_SAT:    nxt_rdata = {24'h00_0000, pair_reg[2]};
			aef_pkg::IDX_PAIR67_SAT:    nxt_rdata = {24'h00_0000, pair_reg[3]};
			aef_pkg::IDX_CHAN_CHECK_EN: nxt_rdata = {24'h00_0000, chan_en_ff};
			aef_pkg::IDX_GEN_FAULT:     nxt_rdata = {24'h00_0000, gen_fault_ff};
			aef_pkg::IDX_GEN_CHECK_EN:  nxt_rdata = {24'h00_0000, gen_en_ff};
			aef_pkg::IDX_SUMMARY_GEN:   nxt_rdata = {24'h00_0000, sum_gen};
			aef_pkg::IDX_SUMMARY_SAT:   nxt_rdata = {24'h00_0000, sum_sat};
			aef_pkg::IDX_IRQ_STATUS:    nxt_rdata = {27'h000_0000, irq_status_ff};
			aef_pkg::IDX_IRQ_MASK:      nxt_rdata = {27'h000_0000, irq_mask_ff};
			default:                    nxt_rdata = 32'h0000_0000;
		endcase
	end

	// ****************************************
	// writable control registers
	// ****************************************
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chan_en_ff <= aef_pkg::RST_CHAN_CHECK_EN; // [R5]
		end else if (wr_now && avs_address_i == aef_pkg::IDX_CHAN_CHECK_EN) begin
			chan_en_ff <= avs_writedata_i[7:0]; // [R5] [R7]
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gen_en_ff <= aef_pkg::RST_GEN_CHECK_EN; // [R13]
		end else if (wr_now && avs_address_i == aef_pkg::IDX_GEN_CHECK_EN) begin
			gen_en_ff <= {2'b00, avs_writedata_i[5:0]};
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_mask_ff <= 5'h00;
		end else if (wr_now && avs_address_i == aef_pkg::IDX_IRQ_MASK) begin
			irq_mask_ff <= avs_writedata_i[4:0];
		end
	end

	// ****************************************
	// per-channel saturation checks
	// ****************************************
	// flags follow the latest check; no write path reaches them
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int c = 0; c < 8; c++) begin
				chan_flags_ff[c] <= 3'b000; // [R1]
			end
		end else begin
			for (int c = 0; c < 8; c++) begin
				chan_flags_ff[c][aef_pkg::BIT_SAT_MOD] <=
					mod_sat_i[c] & chan_en_ff[aef_pkg::BIT_MOD_OVER_ON]; // [R2] [R6] [R16] [R17]
				if (!chan_en_ff[aef_pkg::BIT_FILTER_OVER_ON]) begin
					chan_flags_ff[c][aef_pkg::BIT_SAT_FILTER] <= 1'b0; // [R16]
				end else if (conv_valid_i && conv_chan_i == 3'(c)) begin
					chan_flags_ff[c][aef_pkg::BIT_SAT_FILTER] <=
						magnitude(filt_raw_i) > aef_pkg::FILTER_LIMIT; // [R3] [R6]
				end
				if (!chan_en_ff[aef_pkg::BIT_OUTPUT_CLAMP_ON]) begin
					chan_flags_ff[c][aef_pkg::BIT_SAT_OUTPUT] <= 1'b0; // [R16]
				end else if (conv_valid_i && conv_chan_i == 3'(c)) begin
					chan_flags_ff[c][aef_pkg::BIT_SAT_OUTPUT] <=
						($signed(conv_raw_i) > $signed(conv_limit_pos)) ||
						($signed(conv_raw_i) < $signed(conv_limit_neg)); // [R4] [R6]
				end
			end
		end
	end

	// clamp lands in the same cycle as its flag
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			conv_valid_ff <= 1'b0;
			conv_chan_ff  <= 3'h0;
			conv_data_ff  <= 24'h00_0000;
		end else begin
			conv_valid_ff <= conv_valid_i;
			conv_chan_ff  <= conv_chan_i;
			if ($signed(conv_raw_i) > $signed(conv_limit_pos)) begin
				conv_data_ff <= conv_limit_pos[23:0]; // [R4]
			end else if ($signed(conv_raw_i) < $signed(conv_limit_neg)) begin
				conv_data_ff <= conv_limit_neg[23:0]; // [R4]
			end else begin
				conv_data_ff <= conv_raw_i[23:0];
			end
		end
	end

	// ****************************************
	// periodic crc checks
	// ****************************************
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			crc_tick_cnt_ff <= 10'h000;
		end else if (crc_tick) begin
			crc_tick_cnt_ff <= 10'h000;
		end else begin
			crc_tick_cnt_ff <= crc_tick_cnt_ff + 10'h001;
		end
	end

	// reference refreshed the cycle after any control write, so a legal write never mismatches
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			image_written_ff <= 1'b1;
			golden_crc_ff    <= 8'h00;
		end else begin
			image_written_ff <= wr_now;
			if (image_written_ff) begin
				golden_crc_ff <= crc8(image_word);
			end
		end
	end

	// ****************************************
	// serial port fault checks
	// ****************************************
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			spi_edges_ff <= 6'h00;
		end else if (spi_frame_end_i) begin
			spi_edges_ff <= 6'h00;
		end else if (spi_sclk_edge_i) begin
			spi_edges_ff <= spi_edges_ff + 6'h01; // [R10]
		end
	end

	// ****************************************
	// general fault register
	// ****************************************
	// bits 5..0 each hold the latest outcome of their own check; bits 7..6 stay zero
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gen_fault_ff <= aef_pkg::RST_FLAGS;
		end else begin
			gen_fault_ff[7:6] <= 2'b00;
			if (!gen_en_ff[aef_pkg::BIT_REG_IMAGE_CRC]) begin
				gen_fault_ff[aef_pkg::BIT_REG_IMAGE_CRC] <= 1'b0; // [R16]
			end else if (crc_tick && !image_written_ff && !wr_now) begin
				gen_fault_ff[aef_pkg::BIT_REG_IMAGE_CRC] <= crc8(image_word) != golden_crc_ff; // [R8]
			end
			if (!gen_en_ff[aef_pkg::BIT_FUSE_CRC]) begin
				gen_fault_ff[aef_pkg::BIT_FUSE_CRC] <= 1'b0; // [R16]
			end else if (crc_tick) begin
				gen_fault_ff[aef_pkg::BIT_FUSE_CRC] <= crc8(fuse_data_i) != fuse_crc_i; // [R9]
			end
			if (!gen_en_ff[aef_pkg::BIT_SPI_CLK_COUNT]) begin
				gen_fault_ff[aef_pkg::BIT_SPI_CLK_COUNT] <= 1'b0; // [R16]
			end else if (spi_frame_end_i) begin
				gen_fault_ff[aef_pkg::BIT_SPI_CLK_COUNT] <= spi_edges_ff != (gen_en_ff[aef_pkg::BIT_SPI_CRC] ?
					aef_pkg::SPI_EDGES_CRC : aef_pkg::SPI_EDGES_PLAIN); // [R10]
			end
			if (!gen_en_ff[aef_pkg::BIT_SPI_BAD_READ]) begin
				gen_fault_ff[aef_pkg::BIT_SPI_BAD_READ] <= 1'b0; // [R16]
			end else if (spi_access_i && !spi_access_write_i) begin
				gen_fault_ff[aef_pkg::BIT_SPI_BAD_READ] <= spi_access_addr_i > aef_pkg::SPI_ADDR_LAST; // [R11]
			end
			if (!gen_en_ff[aef_pkg::BIT_SPI_BAD_WRITE]) begin
				gen_fault_ff[aef_pkg::BIT_SPI_BAD_WRITE] <= 1'b0; // [R16]
			end else if (spi_access_i && spi_access_write_i) begin
				gen_fault_ff[aef_pkg::BIT_SPI_BAD_WRITE] <= spi_access_addr_i > aef_pkg::SPI_ADDR_LAST; // [R12]
			end
			if (!gen_en_ff[aef_pkg::BIT_SPI_CRC]) begin
				gen_fault_ff[aef_pkg::BIT_SPI_CRC] <= 1'b0; // [R13] [R16]
			end else if (spi_frame_end_i) begin
				gen_fault_ff[aef_pkg::BIT_SPI_CRC] <= spi_crc_bad_i;
			end
		end
	end

	// ****************************************
	// summaries and interrupt
	// ****************************************
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pair_any_ff <= 4'h0;
			gen_any_ff  <= 1'b0;
		end else begin
			pair_any_ff <= pair_any; // [R14]
			gen_any_ff  <= gen_any; // [R15]
		end
	end

	// rising summaries are the events; a new event beats a same-cycle clear
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_status_ff <= 5'h00;
		end else begin
			for (int b = 0; b < 5; b++) begin
				if (irq_event[b]) begin
					irq_status_ff[b] <= 1'b1;
				end else if (wr_now && avs_address_i == aef_pkg::IDX_IRQ_STATUS && avs_writedata_i[b]) begin
					irq_status_ff[b] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(irq_status_ff & irq_mask_ff);
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign avs_readdata_o    = rdata_ff;
	assign avs_waitrequest_o = wait_ff;
	assign irq_o             = irq_ff;
	assign conv_valid_o      = conv_valid_ff;
	assign conv_chan_o       = conv_chan_ff;
	assign conv_data_o       = conv_data_ff;
endmodule : aef_error_flags
`default_nettype wire

// file: tb/aef_error_flags_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker
// ****************************************
module aef_error_flags_chk (
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        irq_o,
	input wire logic        conv_valid_i,
	input wire logic [2:0]  conv_chan_i,
	input wire logic [27:0] conv_raw_i,
	input wire logic        conv_valid_o,
	input wire logic [2:0]  conv_chan_o,
	input wire logic [23:0] conv_data_o
);
	logic over_hi;
	logic over_lo;
	assign over_hi = $signed(conv_raw_i) > $signed(28'h07f_ffff);
	assign over_lo = $signed(conv_raw_i) < $signed(28'hf80_0000);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	chk_wait_once: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
		!avs_waitrequest_o ##1 avs_waitrequest_o) else $error("wait cycle wrong");
	chk_wait_idle: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
		else $error("waitrequest low while idle");
	chk_read_upper: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	chk_clamp_high: assert property (conv_valid_i && over_hi |=> conv_data_o == 24'h7f_ffff)
		else $error("positive clamp wrong");
	chk_clamp_low: assert property (conv_valid_i && over_lo |=> conv_data_o == 24'h80_0000)
		else $error("negative clamp wrong");
	chk_pass_through: assert property (conv_valid_i && !over_hi && !over_lo |=>
		{{4{conv_data_o[23]}}, conv_data_o} == $past(conv_raw_i)) else $error("in range result altered");
	chk_chan_follow: assert property (conv_valid_i |=> conv_valid_o && conv_chan_o == $past(conv_chan_i))
		else $error("result channel wrong");
	chk_valid_pulse: assert property (!conv_valid_i |=> !conv_valid_o)
		else $error("spurious result valid");
	cov_clamp: cover property (conv_valid_i && over_hi);
	cov_read: cover property (avs_read_i && !avs_waitrequest_o);
	cov_irq: cover property ($rose(irq_o));
endmodule : aef_error_flags_chk
bind aef_error_flags aef_error_flags_chk i_chk (.ref_clk_i, .rst_n_i, .avs_read_i, .avs_write_i,
	.avs_readdata_o, .avs_waitrequest_o, .irq_o, .conv_valid_i, .conv_chan_i, .conv_raw_i,
	.conv_valid_o, .conv_chan_o, .conv_data_o);
`default_nettype wire

// file: tb/aef_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// serial host frame model
// ****************************************
module aef_spi_host (
	input  wire logic       clk_i,
	output logic            sclk_edge_o,
	output logic            frame_end_o,
	output logic            access_o,
	output logic            access_write_o,
	output logic [6:0]      access_addr_o,
	output logic            crc_bad_o
);
	initial begin
		{sclk_edge_o, frame_end_o, access_o, access_write_o, crc_bad_o} = 5'h00;
		access_addr_o = 7'h00;
	end
	// one access per frame, edge count chosen by caller
	task frame(input logic [5:0] n, input logic w, input logic [6:0] a, input logic bad);
		int i;
		@(posedge clk_i);
		access_o <= 1'b1;
		access_write_o <= w;
		access_addr_o <= a;
		crc_bad_o <= bad;
		for (i = 0; i < n; i++) begin
			@(posedge clk_i);
			access_o <= 1'b0;
			access_addr_o <= ~a; // address no longer valid
			sclk_edge_o <= 1'b1;
		end
		@(posedge clk_i);
		sclk_edge_o <= 1'b0;
		frame_end_o <= 1'b1;
		@(posedge clk_i);
		frame_end_o <= 1'b0;
		crc_bad_o <= ~bad;
	endtask : frame
endmodule : aef_spi_host
`default_nettype wire

// file: tb/adc_dsp_and_general_error_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_dsp_and_general_error_flags_tb;
	logic        ref_clk_i, rst_n_i, avs_read_i, avs_write_i, conv_valid_i;
	logic [7:0]  avs_address_i, mod_sat_i, fuse_crc_i;
	logic [31:0] avs_writedata_i, avs_readdata_o;
	logic [3:0]  avs_byteenable_i;
	logic        avs_waitrequest_o, irq_o, conv_valid_o;
	logic [2:0]  conv_chan_i, conv_chan_o, ch;
	logic [27:0] filt_raw_i, conv_raw_i;
	logic [23:0] conv_data_o;
	logic        sclk_e, f_end, acc, acc_w, crc_bad;
	logic [6:0]  acc_a;
	logic [31:0] fuse_d;
	logic [26:0] cq[$];
	logic [31:0] rnd;
	logic [7:0]  exp_q[$], msk_q[$];
	int          fail_count, n_compared, cyc, i;
	logic [7:0]  ri [11] = '{8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5a, 8'h5e, 8'h5f, 8'h71, 8'h20};
	logic [7:0]  rv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hfe, 8'h00, 8'h3e, 8'h00, 8'h00, 8'h00, 8'h00};
	aef_error_flags i_dut (.ref_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o, .mod_sat_i,
		.conv_valid_i, .conv_chan_i, .filt_raw_i, .conv_raw_i, .conv_valid_o, .conv_chan_o, .conv_data_o,
		.fuse_data_i(fuse_d), .fuse_crc_i, .spi_sclk_edge_i(sclk_e), .spi_frame_end_i(f_end),
		.spi_access_i(acc), .spi_access_write_i(acc_w), .spi_access_addr_i(acc_a), .spi_crc_bad_i(crc_bad));
	aef_spi_host i_host (.clk_i(ref_clk_i), .sclk_edge_o(sclk_e), .frame_end_o(f_end), .access_o(acc),
		.access_write_o(acc_w), .access_addr_o(acc_a), .crc_bad_o(crc_bad));
	// ****************************************
	// tasks
	// ****************************************
	function logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	// reference fuse crc: poly 0x07, init 0, msb first
	function logic [7:0] crc_ref(input logic [31:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int k = 31; k >= 0; k--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc_ref
	task cmp_conv(input logic [26:0] got, e);
		n_compared++;
		if (got !== e) begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask : cmp_conv
	task complete_run;
		if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task cmp_reg(input logic [31:0] got, input logic [7:0] e, m);
		n_compared++;
		if ((got & {24'hff_ffff, m}) !== {24'h00_0000, e & m}) begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask : cmp_reg
	task cmp_irq(input logic e);
		n_compared++;
		if (irq_o !== e) begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, irq_o, e);
		end
	endtask : cmp_irq
	// read expectation noted here, checked by the monitor
	task bus(input logic w, input logic [7:0] a, d, input logic [3:0] be, input logic [7:0] e, m);
		@(posedge ref_clk_i);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= {24'h00_0000, d};
		avs_byteenable_i <= be;
		if (!w) exp_q.push_back(e);
		if (!w) msk_q.push_back(m);
		do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : bus
	task conv(input logic [27:0] r, input logic [23:0] e);
		@(posedge ref_clk_i);
		conv_valid_i <= 1'b1;
		conv_raw_i <= r;
		cq.push_back({conv_chan_i, e});
		@(posedge ref_clk_i);
		conv_valid_i <= 1'b0;
	endtask : conv
	always #5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'b0) cmp_reg(avs_readdata_o, exp_q.pop_front(), msk_q.pop_front());
		if (conv_valid_o === 1'b1) cmp_conv({conv_chan_o, conv_data_o}, cq.pop_front());
	end
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			complete_run();
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{ref_clk_i, rst_n_i, avs_read_i, avs_write_i, conv_valid_i} = 5'h00;
		{avs_address_i, mod_sat_i, fuse_crc_i, conv_chan_i, avs_byteenable_i} = 31'h0000_0000;
		{avs_writedata_i, filt_raw_i, conv_raw_i, fuse_d} = 120'h0;
		rnd = 32'h0000_0029;
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		for (i = 0; i < 11; i++) bus(1'b0, ri[i], 8'h00, 4'hf, rv[i], 8'hff);
		bus(1'b1, 8'h54, 8'hff, 4'hf, 8'h00, 8'h00);
		bus(1'b1, 8'h58, 8'h00, 4'h0, 8'h00, 8'h00);
		bus(1'b0, 8'h54, 8'h00, 4'hf, 8'h00, 8'hff);
		bus(1'b0, 8'h58, 8'h00, 4'hf, 8'hfe, 8'hff);
		rnd = xs(rnd);
		bus(1'b1, 8'h58, rnd[7:0], 4'hf, 8'h00, 8'h00);
		bus(1'b0, 8'h58, 8'h00, 4'hf, rnd[7:0], 8'hff);
		bus(1'b1, 8'h58, 8'hfe, 4'hf, 8'h00, 8'h00);
		// saturation on one random channel, clamp of both signs
		rnd = xs(rnd);
		ch = rnd[2:0];
		mod_sat_i <= 8'h01 << ch;
		conv_chan_i <= ch;
		filt_raw_i <= 28'h100_0000;
		conv(28'h000_1234, 24'h00_1234);
		conv(28'hf70_0000, 24'h80_0000);
		conv(28'h080_0000 | {12'h000, rnd[15:0]}, 24'h7f_ffff);
		bus(1'b0, 8'h54 + {6'h00, ch[2:1]}, 8'h00, 4'hf, 8'h07 << (3 * ch[0]), 8'h3f);
		bus(1'b0, 8'h5f, 8'h00, 4'hf, 8'h20 | (8'h01 << ch[2:1]), 8'h2f);
		bus(1'b0, 8'h70, 8'h00, 4'hf, 8'h01 << ch[2:1], 8'hff);
		cmp_irq(1'b0);
		// all three saturation checks off
		bus(1'b1, 8'h58, 8'h1e, 4'hf, 8'h00, 8'h00);
		bus(1'b0, 8'h54 + {6'h00, ch[2:1]}, 8'h00, 4'hf, 8'h00, 8'hff);
		bus(1'b1, 8'h71, 8'h1f, 4'hf, 8'h00, 8'h00);
		repeat (3) @(posedge ref_clk_i);
		cmp_irq(1'b1);
		bus(1'b1, 8'h70, 8'hff, 4'hf, 8'h00, 8'h00);
		repeat (3) @(posedge ref_clk_i);
		cmp_irq(1'b0);
		// general faults; fuse reference deliberately wrong first
		fuse_d <= rnd;
		fuse_crc_i <= ~crc_ref(rnd);
		i_host.frame(6'd15, 1'b0, 7'h70, 1'b1);
		repeat (1005) @(posedge ref_clk_i);
		bus(1'b0, 8'h59, 8'h00, 4'hf, 8'h1c, 8'h3f);
		bus(1'b0, 8'h5e, 8'h00, 4'hf, 8'h28, 8'h28);
		cmp_irq(1'b1);
		i_host.frame(6'd16, 1'b1, 7'h64, 1'b0);
		bus(1'b0, 8'h59, 8'h00, 4'hf, 8'h02, 8'h0a);
		bus(1'b1, 8'h5a, 8'h3f, 4'hf, 8'h00, 8'h00);
		i_host.frame(6'd24, 1'b0, 7'h63, 1'b1);
		bus(1'b0, 8'h59, 8'h00, 4'hf, 8'h01, 8'h0d);
		// matching fuse reference clears the fuse fault at the next tick
		fuse_crc_i <= crc_ref(fuse_d);
		repeat (1005) @(posedge ref_clk_i);
		bus(1'b0, 8'h59, 8'h00, 4'hf, 8'h00, 8'h10);
		repeat (3) @(posedge ref_clk_i);
		complete_run();
	end
endmodule : adc_dsp_and_general_error_flags_tb
`default_nettype wire
